// *** core/event_latch_bank.sv ***
`include "status_irq_defines.svh"

module event_latch_bank
  import status_irq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire event_vec_t event_in,
  input  wire event_vec_t clear_in,
  output event_vec_t      seen_out
);
  event_vec_t seen_q;
  event_vec_t seen_d;

  // Sticky latches; an event in the clear cycle survives the clear
  genvar i;
  generate
    for (i = 0; i < `EVENT_COUNT; i++) begin : g_latch
      assign seen_d[i] = event_in[i] | (seen_q[i] & ~clear_in[i]);
    end
  endgenerate

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seen_q <= `RST_EVENT_SEEN;
    end else begin
      seen_q <= seen_d;
    end
  end

  assign seen_out = seen_q;
endmodule // event_latch_bank

// *** core/status_interrupt_bank.sv ***
`include "status_irq_defines.svh"

// Operation
// - Synth lock-loss enable gates its latched interrupt
// - Jitter PLL lock-loss enable gates its interrupt
// - Per-input loss enables gate input loss interrupts
// - Reference-loss enable gates reference latch interrupt
// - Holdover enable gates holdover latch interrupt
// - All enables reset to zero, read/write
// - Synth lock latch reads zero after loss
// - Writing one clears synth latch and interrupt
// - Jitter PLL latch reads zero after loss
// - Write one clears jitter latch; zero ignored
// - Latched register holds ref, hold, inputs low
// - Momentary register shows selection and live states
// - Calibration register carries only bit two
// - Input latches read zero after loss, W1C
// - Reference latch reads zero after loss, W1C
// - Holdover latch reads zero after entry, W1C
// - Calibration bit one while calibration runs
module status_interrupt_bank
  import status_irq_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      sys_rst_in,
  // Decoded register access from the serial configuration port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic      reg_wr_in,
  input  wire logic      reg_rd_in,
  input  wire reg_byte_t reg_wdata_in,
  output reg_byte_t      reg_rdata_out,
  output logic           reg_rvalid_out,
  // Live detector levels; for the six event sources one means healthy
  input  wire logic      selected_input_now,
  input  wire logic      synth_lock_now,
  input  wire logic      jitter_pll_lock_now,
  input  wire logic      ref_present_now,
  input  wire logic      holdover_now,
  input  wire logic      input1_active_now,
  input  wire logic      input0_active_now,
  input  wire logic      synth_cal_active,
  // Active-low interrupt pin
  output logic           irq_out_low
);

  // Address match, used by both the read and write decode
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    addr_is = (addr == ofs);
  endfunction

  logic [7:0] raw_status;
  logic [7:0] live_status;
  event_vec_t live_events;
  event_vec_t seen;
  event_vec_t irq_en_q;
  event_vec_t irq_en_d;
  event_vec_t clear_req;
  event_vec_t pending;
  reg_byte_t  latched_view;
  reg_byte_t  momentary_view;
  reg_byte_t  cal_view;
  reg_byte_t  rdata_d;
  reg_byte_t  rdata_q;
  logic       rvalid_q;
  logic       irq_low_q;
  logic       wr_enable_reg;
  logic       wr_latched_reg;
  logic       rd_enable_reg;
  logic       rd_latched_reg;
  logic       rd_momentary_reg;
  logic       rd_cal_reg;

  // Gather detector levels into one synchronised word
  assign raw_status = {synth_cal_active,
                       selected_input_now,
                       synth_lock_now,
                       jitter_pll_lock_now,
                       ref_present_now,
                       holdover_now,
                       input1_active_now,
                       input0_active_now};

  status_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (raw_status),
    .sync_out   (live_status)
  );

  // Each of live bits 5:0 is low in its event state, so the event is its inverse
  assign live_events = ~live_status[5:0];

  // Address and strobe decode
  assign wr_enable_reg    = reg_wr_in & addr_is(reg_addr_in, `OFS_EVENT_IRQ_EN);
  assign wr_latched_reg   = reg_wr_in & addr_is(reg_addr_in, `OFS_LATCHED_FLAGS);
  assign rd_enable_reg    = addr_is(reg_addr_in, `OFS_EVENT_IRQ_EN);
  assign rd_latched_reg   = addr_is(reg_addr_in, `OFS_LATCHED_FLAGS);
  assign rd_momentary_reg = addr_is(reg_addr_in, `OFS_MOMENTARY_STATUS);
  assign rd_cal_reg       = addr_is(reg_addr_in, `OFS_CAL_STATUS);

  // Only ones clear; zeros in the write data leave latches alone
  assign clear_req = wr_latched_reg ? reg_wdata_in[5:0] : '0;

  event_latch_bank u_latches (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .event_in   (live_events),
    .clear_in   (clear_req),
    .seen_out   (seen)
  );

  // Enable register; reserved bits are not stored
  assign irq_en_d = wr_enable_reg ? reg_wdata_in[5:0] : irq_en_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_en_q <= `RST_IRQ_EN;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // Latched flags read zero once an event was seen
  assign latched_view = {2'b00, ~seen};

  // Momentary view: selected input on top, live levels below
  assign momentary_view = {1'b0, live_status[6:0]};

  // Calibration register holds one live bit, rest reserved zero
  assign cal_view = {5'b00000, live_status[7], 2'b00};

  // Read mux; unmapped addresses return zero
  always_comb begin
    if (rd_enable_reg) begin
      rdata_d = {2'b00, irq_en_q};
    end else if (rd_latched_reg) begin
      rdata_d = latched_view;
    end else if (rd_momentary_reg) begin
      rdata_d = momentary_view;
    end else if (rd_cal_reg) begin
      rdata_d = cal_view;
    end else begin
      rdata_d = `RST_READ_DATA;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q  <= `RST_READ_DATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Each source gated by its own enable
  assign pending[`POS_SYNTH_LOCK]  = seen[`POS_SYNTH_LOCK]  & irq_en_q[`POS_SYNTH_LOCK];
  assign pending[`POS_JITTER_LOCK] = seen[`POS_JITTER_LOCK] & irq_en_q[`POS_JITTER_LOCK];
  assign pending[`POS_REF]         = seen[`POS_REF]         & irq_en_q[`POS_REF];
  assign pending[`POS_HOLDOVER]    = seen[`POS_HOLDOVER]    & irq_en_q[`POS_HOLDOVER];
  assign pending[`POS_INPUT1]      = seen[`POS_INPUT1]      & irq_en_q[`POS_INPUT1];
  assign pending[`POS_INPUT0]      = seen[`POS_INPUT0]      & irq_en_q[`POS_INPUT0];

  // Registered pin so it never glitches while latches change
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_low_q <= 1'b1;
    end else begin
      irq_low_q <= ~(|pending);
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign irq_out_low    = irq_low_q;
endmodule // status_interrupt_bank

// *** core/status_irq_defines.svh ***
`ifndef STATUS_IRQ_DEFINES_SVH
`define STATUS_IRQ_DEFINES_SVH

// Register offsets on the configuration port
`define OFS_EVENT_IRQ_EN     8'h4c
`define OFS_LATCHED_FLAGS    8'h50
`define OFS_MOMENTARY_STATUS 8'h51
`define OFS_CAL_STATUS       8'h53

// Field positions shared by enable, latched and momentary registers, plus the calibration register bit
`define POS_SYNTH_LOCK       5
`define POS_JITTER_LOCK      4
`define POS_REF              3
`define POS_HOLDOVER         2
`define POS_INPUT1           1
`define POS_INPUT0           0
`define POS_SELECTED_INPUT   6
`define POS_SYNTH_CAL        2

// Number of event sources and reset values
`define EVENT_COUNT          6
`define RST_IRQ_EN           6'h00
`define RST_EVENT_SEEN       6'h00
`define RST_READ_DATA        8'h00

// Depth of the input synchroniser
`define SYNC_STAGES          2

`endif

// *** core/status_irq_pkg.sv ***
package status_irq_pkg;
  // One bit per event source, ordered as in the register fields
  typedef logic [5:0] event_vec_t;
  // One register byte
  typedef logic [7:0] reg_byte_t;
endpackage

// *** core/status_sync.sv ***
`include "status_irq_defines.svh"

module status_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Detector levels come from analog monitors, so two flops before use
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // status_sync

// *** tb/status_host_model.sv ***
module status_host_model (
  input  wire logic clk_in,
  output logic [7:0] addr_out,
  output logic       wr_out,
  output logic       rd_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] exp_q[$];
  initial begin
    {addr_out, wr_out, rd_out, wdata_out} = '0;
  end
  // One-cycle strobe; released address and data show inverse so stale data never matches
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} <= {w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(posedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} <= {1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // status_host_model

// *** tb/status_interrupt_bank_tb.sv ***
module status_interrupt_bank_tb;
  import status_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, sys_rst_in, sel, cal, wr, rd, rvalid, irq;
  logic [5:0] live;
  logic [7:0] addr, wdata;
  logic [31:0] v;
  reg_byte_t rdata;
  int bad_count = 0, comparisons = 0, cyc = 0, i;
  always #4 clk_in = ~clk_in;
  status_host_model status_host_model_i (.clk_in(clk_in), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  status_interrupt_bank status_interrupt_bank_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .selected_input_now(sel),
    .synth_lock_now(live[5]), .jitter_pll_lock_now(live[4]), .ref_present_now(live[3]),
    .holdover_now(live[2]), .input1_active_now(live[1]), .input0_active_now(live[0]),
    .synth_cal_active(cal), .irq_out_low(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_in);
    #1 check({7'h00, irq}, {7'h00, exp});
  endtask
  // Oldest noted read expectation against each answer
  always @(posedge clk_in) begin
    if (rvalid === 1'b1) check(rdata, status_host_model_i.exp_q.pop_front());
  end
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    v = $urandom(32'h7778a991);
    {sys_rst_in, live, sel, cal} = {1'b1, 6'h3f, 2'b00};
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    status_host_model_i.access(0, 8'h4c, 8'h00);
    status_host_model_i.access(1, 8'h50, 8'h3f);
    status_host_model_i.access(0, 8'h50, 8'h3f);
    v = $urandom;
    status_host_model_i.access(1, 8'h4c, v[7:0]);
    status_host_model_i.access(0, 8'h4c, {2'b00, v[5:0]});
    status_host_model_i.access(1, 8'h4c, 8'h00);
    $display("test enables done");
    for (i = 0; i < 6; i++) begin
      @(posedge clk_in) live <= 6'h3f ^ (6'h01 << i);
      repeat (4) @(posedge clk_in);
      live <= 6'h3f;
      irq_is(1'b1);
      status_host_model_i.access(1, 8'h4c, 8'h01 << i);
      irq_is(1'b0);
      status_host_model_i.access(1, 8'h50, 8'h00);
      status_host_model_i.access(0, 8'h50, 8'h3f ^ (8'h01 << i));
      status_host_model_i.access(1, 8'h50, 8'h01 << i);
      irq_is(1'b1);
      status_host_model_i.access(1, 8'h4c, 8'h00);
    end
    $display("test latches done");
    v = $urandom;
    @(posedge clk_in) {cal, sel, live} <= v[7:0];
    repeat (4) @(posedge clk_in);
    status_host_model_i.access(1, 8'h51, 8'hff);
    status_host_model_i.access(0, 8'h51, {1'b0, v[6:0]});
    status_host_model_i.access(0, 8'h53, {5'h00, v[7], 2'b00});
    // Low levels held long enough for the checker's latch assertions to see
    status_host_model_i.access(0, 8'h50, {2'b00, v[5:0]});
    // Clear while events persist: set wins, so lost sources stay latched
    status_host_model_i.access(1, 8'h50, 8'h3f);
    status_host_model_i.access(0, 8'h50, {2'b00, v[5:0]});
    status_host_model_i.access(0, 8'h52, 8'h00);
    repeat (3) @(posedge clk_in);
    $display("test status done");
    final_report();
  end
endmodule // status_interrupt_bank_tb

// *** tb/status_irq_checker.sv ***
module status_irq_checker
  import status_irq_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire reg_byte_t  reg_wdata_in,
  input wire reg_byte_t  reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       synth_lock_now,
  input wire logic       ref_present_now,
  input wire logic       input0_active_now,
  input wire logic       irq_out_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Five low samples clear the synchroniser before the read edge
  sequence s_rd50; reg_rd_in && reg_addr_in == 8'h50; endsequence
  sequence s_rd51; reg_rd_in && reg_addr_in == 8'h51; endsequence
  sequence s_rd53; reg_rd_in && reg_addr_in == 8'h53; endsequence
  AST_RVALID: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read answer missing");
  AST_NO_RVALID: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read answer without request");
  AST_CAL_RSVD: assert property (s_rd53 |=> (reg_rdata_out & 8'hfb) == 8'h00)
    else $error("calibration reserved bits set");
  AST_MOM_RSVD: assert property (s_rd51 |=> !reg_rdata_out[7])
    else $error("momentary bit 7 set");
  AST_LAT_RSVD: assert property (s_rd50 |=> reg_rdata_out[7:6] == 2'b00)
    else $error("latched reserved bits set");
  AST_SYNTH_LATCH: assert property (!synth_lock_now [*5] ##0 s_rd50 |=> !reg_rdata_out[5])
    else $error("synth lock loss not latched");
  AST_REF_LATCH: assert property (!ref_present_now [*5] ##0 s_rd50 |=> !reg_rdata_out[3])
    else $error("reference loss not latched");
  AST_IN0_LATCH: assert property (!input0_active_now [*5] ##0 s_rd50 |=> !reg_rdata_out[0])
    else $error("input 0 loss not latched");
  AST_IRQ_RELEASE: assert property ((reg_wr_in && reg_addr_in == 8'h4c
    && reg_wdata_in[5:0] == 6'h00) |=> ##1 irq_out_low)
    else $error("interrupt held with all enables off");
endmodule // status_irq_checker

bind status_interrupt_bank status_irq_checker status_irq_checker_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .synth_lock_now(synth_lock_now), .ref_present_now(ref_present_now),
  .input0_active_now(input0_active_now), .irq_out_low(irq_out_low));
